// ===== uart_afc_consts.svh
`ifndef UART_AFC_CONSTS_SVH
`define UART_AFC_CONSTS_SVH
// Register indices on the plain host port
`define ADDR_INT_EN     4'h0
`define ADDR_FIFO_CTL   4'h1
`define ADDR_INT_STAT   4'h2
`define ADDR_LINE_CTL   4'h3
`define ADDR_MODEM_CTL  4'h4
`define ADDR_LINE_STAT  4'h5
`define ADDR_MODEM_STAT 4'h6
`define ADDR_SCRATCH    4'h7
`define ADDR_FEATURE    4'h8
`define ADDR_RESUME1    4'h9
`define ADDR_RESUME2    4'hA
`define ADDR_PAUSE1     4'hB
`define ADDR_PAUSE2     4'hC
`define ADDR_FEAT_CTL   4'hD
`define ADDR_TRIG       4'hE
`define ADDR_IRQ_STAT   4'hF
// Reset values and status codes
`define RST_ZERO        8'h00
`define RST_NO_INT      8'h01
`define RST_LINE_STAT   8'h60
`define RST_SCRATCH     8'hFF
`define RST_TRIG        8'h08
`define INT_PENDING     8'h04
// Field positions and shifts
`define AUTO_RTS_BIT    6
`define AUTO_CTS_BIT    7
`define RTS_CTL_BIT     1
`define DTR_CTL_BIT     0
`define OUT1_CTL_BIT    2
`define OUT2_CTL_BIT    3
`define CTS_SYNC_BIT    0
`define HYST_SHIFT      2
`define IRQ_TRIG        0
`define IRQ_CTS         1
`define IRQ_MASK_BIT    4
`endif

// ===== uart_afc_pkg.sv
package uart_afc_pkg;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} host_req_s;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_HALT  = 2'b10
	} tx_state_e;
endpackage

// ===== uart_auto_flow_and_reset.sv
// Summary of operation
// - Auto request-to-send: interrupt at trigger, release pin at upper hysteresis
// - Auto request-to-send asserts again when fill drops below lower level
// - Automatic control only acts once software has asserted request-to-send
// - Without hardware flow control the pin follows its control bit
// - Auto clear-to-send halts transmission while input is high; default off
// - Four read/write flow-control characters: two resume, two pause
// - Interrupt enable, FIFO, line and modem control reset to zero
// - Interrupt status resets to no interrupt pending
// - Line status resets with transmitter and holding register empty
// - Scratch pad resets to all ones
// - Modem status low nibble clear, high nibble inverted modem inputs
// - Divisor and holding registers carry no guaranteed reset value
// - Feature and character registers reset zero; trigger level register resets to 08
// - Transmit, user outputs, request-to-send, terminal-ready reset high
// - Receive-ready resets high in strobe mode, released in PC mode
// - Transmit-ready and interrupt reset low in strobe mode, else released
// - Two-bit hysteresis field; zero means switch four above and four below the trigger
`timescale 1ns/1ns
`include "uart_afc_consts.svh"
module uart_auto_flow_and_reset #(
	parameter int FIFO_DEPTH = 64,
	parameter int CW         = 7
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// Host register port
	input  wire uart_afc_pkg::host_req_s host_req,
	output logic [7:0]                  rd_data,
	// Bus mode strap: 1 strobe-style, 0 PC mode
	input  wire logic                   strobe_mode,
	// Receive FIFO fill from datapath
	input  wire logic [CW-1:0]          rx_fill,
	// Transmitter handshake with the datapath
	input  wire logic                   tx_char_start,
	input  wire logic                   tx_char_done,
	output logic                        tx_allow,
	// Modem pins
	input  wire logic                   cts_n_pin,
	input  wire logic                   dsr_n_pin,
	input  wire logic                   ri_n_pin,
	input  wire logic                   cd_n_pin,
	output logic                        rts_n,
	output logic                        dtr_n,
	output logic                        user_output_first_n,
	output logic                        user_output_second_n,
	output logic                        tx_line,
	// Ready and interrupt pins with enables (low enable drives)
	output logic                        receive_ready_n,
	output logic                        receive_ready_oe_n,
	output logic                        transmit_ready_n,
	output logic                        transmit_ready_oe_n,
	output logic                        irq,
	output logic                        irq_oe_n
);
	logic [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg;
	logic [7:0] modem_control_reg, scratch_pad_reg;
	logic [7:0] enhanced_feature_control, feature_control_reg;
	logic [7:0] flow_resume_char_first, flow_resume_char_second;
	logic [7:0] flow_pause_char_first, flow_pause_char_second;
	logic [7:0] trig_reg, modem_delta_reg, irq_stat_reg;
	logic [3:0] modem_sync1_reg, modem_sync2_reg;
	logic       rts_auto_reg, rts_armed_reg, trig_seen_reg, cts_prev_reg;
	uart_afc_pkg::tx_state_e tx_state_reg, tx_state_next;

	// Decode of host strobes
	wire wr_en = host_req.wr;
	wire [3:0] a = host_req.addr;
	wire auto_rts = enhanced_feature_control[`AUTO_RTS_BIT];
	wire auto_cts = enhanced_feature_control[`AUTO_CTS_BIT];
	wire cts_hi = modem_sync2_reg[`CTS_SYNC_BIT];

	// Hysteresis levels around the trigger
	wire [1:0] hyst = feature_control_reg[1:0];
	wire [CW:0] hyst_span = ({{(CW-1){1'b0}}, hyst} + 1'b1) << `HYST_SHIFT;
	wire [CW:0] trig_w = {1'b0, trig_reg[CW-1:0]};
	wire [CW:0] upper_lvl = trig_w + hyst_span;
	wire [CW:0] lower_lvl = (trig_w > hyst_span) ? trig_w - hyst_span
		: {(CW+1){1'b0}};
	wire [CW:0] fill_w = {1'b0, rx_fill};
	wire at_trig = fill_w >= trig_w;

	// Host writes of plain registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			interrupt_enable_reg     <= `RST_ZERO;
			fifo_control_reg         <= `RST_ZERO;
			line_control_reg         <= `RST_ZERO;
			modem_control_reg        <= `RST_ZERO;
			scratch_pad_reg          <= `RST_SCRATCH;
			enhanced_feature_control <= `RST_ZERO;
			feature_control_reg      <= `RST_ZERO;
			flow_resume_char_first   <= `RST_ZERO;
			flow_resume_char_second  <= `RST_ZERO;
			flow_pause_char_first    <= `RST_ZERO;
			flow_pause_char_second   <= `RST_ZERO;
			trig_reg                 <= `RST_TRIG;
		end else if (wr_en) begin
			case (a)
			`ADDR_INT_EN:    interrupt_enable_reg <= host_req.wdata;
			`ADDR_FIFO_CTL:  fifo_control_reg <= host_req.wdata;
			`ADDR_LINE_CTL:  line_control_reg <= host_req.wdata;
			`ADDR_MODEM_CTL: modem_control_reg <= host_req.wdata;
			`ADDR_SCRATCH:   scratch_pad_reg <= host_req.wdata;
			`ADDR_FEATURE:   enhanced_feature_control <= host_req.wdata;
			`ADDR_RESUME1:   flow_resume_char_first <= host_req.wdata;
			`ADDR_RESUME2:   flow_resume_char_second <= host_req.wdata;
			`ADDR_PAUSE1:    flow_pause_char_first <= host_req.wdata;
			`ADDR_PAUSE2:    flow_pause_char_second <= host_req.wdata;
			`ADDR_FEAT_CTL:  feature_control_reg <= host_req.wdata;
			`ADDR_TRIG:  trig_reg <= host_req.wdata;
			default: ;
			endcase
		end
	end

	// Modem inputs through two flops; the clear-to-send delta bit latches changes
	always_ff @(posedge sys_clk) begin
		modem_sync1_reg <= {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
		modem_sync2_reg <= modem_sync1_reg;
		if (rst) begin
			modem_delta_reg <= `RST_ZERO;
			cts_prev_reg    <= cts_hi;
		end else begin
			cts_prev_reg    <= cts_hi;
			modem_delta_reg <= (wr_en || !host_req.rd
				|| a != `ADDR_MODEM_STAT)
				? (modem_delta_reg | {7'h00, cts_prev_reg ^ cts_hi})
				: {7'h00, cts_prev_reg ^ cts_hi};
		end
	end

	// Request-to-send: armed by software, hysteresis when automatic
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rts_armed_reg <= 1'b0;
			rts_auto_reg  <= 1'b0;
		end else begin
			if (modem_control_reg[`RTS_CTL_BIT])
				rts_armed_reg <= 1'b1;
			else
				rts_armed_reg <= 1'b0;
			if (!auto_rts || !rts_armed_reg)
				rts_auto_reg <= 1'b0;
			else if (fill_w >= upper_lvl)
				rts_auto_reg <= 1'b1;
			else if (fill_w < lower_lvl)
				rts_auto_reg <= 1'b0;
		end
	end

	// Sticky interrupt status; set wins over write-one-to-clear
	wire [1:0] ev = {cts_prev_reg ^ cts_hi, at_trig & ~trig_seen_reg};
	wire clr_irq = wr_en && a == `ADDR_IRQ_STAT;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_stat_reg  <= `RST_ZERO;
			trig_seen_reg <= 1'b0;
		end else begin
			trig_seen_reg <= at_trig;
			irq_stat_reg[1:0] <= (irq_stat_reg[1:0]
				& ~(clr_irq ? host_req.wdata[1:0] : 2'b00))
				| ({2{auto_rts}} & ev);
		end
	end

	// Transmit gate: a character in flight always completes
	always_comb begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
		uart_afc_pkg::TX_IDLE:
			if (tx_char_start)
				tx_state_next = uart_afc_pkg::TX_SHIFT;
			else if (auto_cts && cts_hi)
				tx_state_next = uart_afc_pkg::TX_HALT;
		uart_afc_pkg::TX_SHIFT:
			if (tx_char_done)
				tx_state_next = (auto_cts && cts_hi)
					? uart_afc_pkg::TX_HALT
					: uart_afc_pkg::TX_IDLE;
		uart_afc_pkg::TX_HALT:
			if (!(auto_cts && cts_hi))
				tx_state_next = uart_afc_pkg::TX_IDLE;
		default:
			tx_state_next = uart_afc_pkg::TX_IDLE;
		endcase
	end

	// Read mux; divisor and holding data live in the datapath
	wire [7:0] modem_stat_val = {~modem_sync2_reg, 4'h0}
		| {4'h0, modem_delta_reg[3:0]};
	wire any_irq = |(irq_stat_reg[1:0] & interrupt_enable_reg[1:0]);
	wire [7:0] int_status_val = any_irq ? `INT_PENDING : `RST_NO_INT;
	logic [7:0] rd_mux;
	always_comb begin
		case (a)
		`ADDR_INT_EN:     rd_mux = interrupt_enable_reg;
		`ADDR_FIFO_CTL:   rd_mux = fifo_control_reg;
		`ADDR_INT_STAT:   rd_mux = int_status_val;
		`ADDR_LINE_CTL:   rd_mux = line_control_reg;
		`ADDR_MODEM_CTL:  rd_mux = modem_control_reg;
		`ADDR_LINE_STAT:  rd_mux = `RST_LINE_STAT;
		`ADDR_MODEM_STAT: rd_mux = modem_stat_val;
		`ADDR_SCRATCH:    rd_mux = scratch_pad_reg;
		`ADDR_FEATURE:    rd_mux = enhanced_feature_control;
		`ADDR_RESUME1:    rd_mux = flow_resume_char_first;
		`ADDR_RESUME2:    rd_mux = flow_resume_char_second;
		`ADDR_PAUSE1:     rd_mux = flow_pause_char_first;
		`ADDR_PAUSE2:     rd_mux = flow_pause_char_second;
		`ADDR_FEAT_CTL:   rd_mux = feature_control_reg;
		`ADDR_TRIG:     rd_mux = trig_reg;
		`ADDR_IRQ_STAT: rd_mux = irq_stat_reg;
		default:        rd_mux = `RST_ZERO;
		endcase
	end

	// Output flops: pins and read data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_state_reg         <= uart_afc_pkg::TX_IDLE;
			rd_data              <= `RST_ZERO;
			tx_allow             <= 1'b1;
			rts_n                <= 1'b1;
			dtr_n                <= 1'b1;
			user_output_first_n  <= 1'b1;
			user_output_second_n <= 1'b1;
			tx_line              <= 1'b1;
			receive_ready_n      <= 1'b1;
			receive_ready_oe_n   <= ~strobe_mode;
			transmit_ready_n     <= 1'b0;
			transmit_ready_oe_n  <= ~strobe_mode;
			irq                  <= 1'b0;
			irq_oe_n             <= ~strobe_mode;
		end else begin
			tx_state_reg <= tx_state_next;
			rd_data <= host_req.rd ? rd_mux : `RST_ZERO;
			tx_allow <= tx_state_next != uart_afc_pkg::TX_HALT;
			rts_n <= auto_rts ? (~rts_armed_reg | rts_auto_reg)
				: ~modem_control_reg[`RTS_CTL_BIT];
			dtr_n <= ~modem_control_reg[`DTR_CTL_BIT];
			user_output_first_n  <= ~modem_control_reg[`OUT1_CTL_BIT];
			user_output_second_n <= ~modem_control_reg[`OUT2_CTL_BIT];
			tx_line <= 1'b1;
			receive_ready_n <= ~at_trig;
			receive_ready_oe_n <= ~strobe_mode;
			transmit_ready_n <= 1'b0;
			transmit_ready_oe_n <= ~strobe_mode;
			irq <= any_irq;
			irq_oe_n <= ~strobe_mode;
		end
	end

	// Checks
	sequence s_rts_high_cause;
		auto_rts && rts_armed_reg && fill_w >= upper_lvl;
	endsequence
	a_rts_upper_release: assert property (@(posedge sys_clk) disable iff (rst)
		s_rts_high_cause |=> ##1 rts_n)
		else $error("rts not released at upper level");
	a_rts_lower_assert: assert property (@(posedge sys_clk) disable iff (rst)
		auto_rts && rts_armed_reg && fill_w < lower_lvl
		&& $stable(rts_armed_reg) |=> ##1 !rts_n)
		else $error("rts not asserted below lower level");
	a_rts_needs_arm: assert property (@(posedge sys_clk) disable iff (rst)
		!rts_armed_reg |-> !rts_auto_reg)
		else $error("auto rts acted before arm");
	a_rts_gpio_follow: assert property (@(posedge sys_clk) disable iff (rst)
		!auto_rts |=> rts_n == !$past(modem_control_reg[`RTS_CTL_BIT]))
		else $error("rts not following control bit");
	a_cts_halt_tx: assert property (@(posedge sys_clk) disable iff (rst)
		tx_state_reg == uart_afc_pkg::TX_HALT |-> !tx_allow)
		else $error("tx allowed while halted");
	a_cts_finish_char: assert property (@(posedge sys_clk) disable iff (rst)
		tx_state_reg == uart_afc_pkg::TX_SHIFT && !tx_char_done
		|=> tx_state_reg == uart_afc_pkg::TX_SHIFT)
		else $error("character cut short");
	a_reset_scratch_ones: assert property (@(posedge sys_clk)
		rst |=> scratch_pad_reg == `RST_SCRATCH
		&& modem_control_reg == `RST_ZERO)
		else $error("bad scratch or modem control reset");
	a_reset_pins_high: assert property (@(posedge sys_clk)
		rst |=> rts_n && dtr_n && tx_line && !irq)
		else $error("bad pin reset");
	a_xon_readback: assert property (@(posedge sys_clk) disable iff (rst)
		host_req.wr && a == `ADDR_RESUME1 ##1 host_req.rd
		&& a == `ADDR_RESUME1
		&& !host_req.wr |=> rd_data == $past(flow_resume_char_first))
		else $error("resume char readback wrong");
	// Reset leaves every control register cleared
	a_reset_ctrl_zero: assert property (@(posedge sys_clk)
		rst |=> interrupt_enable_reg == `RST_ZERO
		&& fifo_control_reg == `RST_ZERO
		&& line_control_reg == `RST_ZERO
		&& modem_control_reg == `RST_ZERO)
		else $error("control register not cleared by reset");
	a_reset_feature_zero: assert property (@(posedge sys_clk)
		rst |=> enhanced_feature_control == `RST_ZERO
		&& feature_control_reg == `RST_ZERO
		&& flow_resume_char_first == `RST_ZERO
		&& flow_resume_char_second == `RST_ZERO
		&& flow_pause_char_first == `RST_ZERO
		&& flow_pause_char_second == `RST_ZERO)
		else $error("feature register not cleared by reset");
	// Status code and modem deltas straight after reset
	a_reset_no_pending: assert property (@(posedge sys_clk)
		rst |=> int_status_val == `RST_NO_INT)
		else $error("interrupt pending after reset");
	a_reset_modem_delta: assert property (@(posedge sys_clk)
		rst |=> modem_delta_reg == `RST_ZERO)
		else $error("modem delta bits set after reset");
	// Ready and interrupt pins after reset follow the bus mode strap
	a_reset_ready_pins: assert property (@(posedge sys_clk)
		rst |=> receive_ready_n
		&& receive_ready_oe_n == !$past(strobe_mode))
		else $error("receive ready bad after reset");
	a_reset_int_pins: assert property (@(posedge sys_clk)
		rst |=> !transmit_ready_n && !irq
		&& transmit_ready_oe_n == !$past(strobe_mode)
		&& irq_oe_n == !$past(strobe_mode))
		else $error("transmit ready or interrupt bad after reset");
	// A trigger event sets its sticky bit even against a clear
	sequence s_trig_event;
		auto_rts && at_trig && !trig_seen_reg;
	endsequence
	a_stat_set_wins: assert property (@(posedge sys_clk)
		disable iff (rst) s_trig_event |=> irq_stat_reg[`IRQ_TRIG])
		else $error("trigger status bit not set");
	// Interrupt pin is the registered masked status
	a_irq_level: assert property (@(posedge sys_clk)
		disable iff (rst) 1'b1 |=> irq == $past(any_irq))
		else $error("interrupt pin does not follow status");
	// A start wins over a halt; otherwise clear-to-send halts sending
	a_cts_idle_halt: assert property (@(posedge sys_clk)
		disable iff (rst) tx_state_reg == uart_afc_pkg::TX_IDLE
		&& auto_cts && cts_hi && !tx_char_start |=> !tx_allow)
		else $error("transmitter not halted by clear-to-send");
	a_cts_start_kept: assert property (@(posedge sys_clk)
		disable iff (rst) tx_state_reg == uart_afc_pkg::TX_IDLE
		&& tx_char_start |=> tx_state_reg == uart_afc_pkg::TX_SHIFT)
		else $error("character start lost");
	// Automatic clear-to-send is off after reset
	a_cts_default_off: assert property (@(posedge sys_clk)
		rst |=> !auto_cts && tx_allow)
		else $error("automatic clear-to-send on after reset");
endmodule // uart_auto_flow_and_reset

// ===== remote_modem_model.sv
`timescale 1ns/1ns
module remote_modem_model (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Bench asks the remote to hold off our sender
	input  wire logic pause_req,
	// Device permission to start a character
	input  wire logic tx_allow,
	// Modem lines and transmitter pulses
	output logic      cts_n_pin,
	output logic      dsr_n_pin,
	output logic      ri_n_pin,
	output logic      cd_n_pin,
	output logic      tx_char_start,
	output logic      tx_char_done
);
	logic [3:0] bit_cnt_reg;
	logic       busy_reg;
	// Lines this remote never toggles sit at fixed levels
	assign dsr_n_pin = 1'b1;
	assign ri_n_pin  = 1'b1;
	assign cd_n_pin  = 1'b0;
	assign cts_n_pin = pause_req;
	// Starts a character whenever allowed and idle; ten cycles for the first after reset, sixteen after
	always_ff @(posedge sys_clk) begin
		tx_char_start <= 1'b0;
		tx_char_done  <= 1'b0;
		if (rst) begin
			busy_reg    <= 1'b0;
			bit_cnt_reg <= 4'h0;
		end else if (busy_reg) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (bit_cnt_reg == 4'h9) begin
				busy_reg     <= 1'b0;
				tx_char_done <= 1'b1;
			end
		end else if (tx_allow) begin
			busy_reg      <= 1'b1;
			tx_char_start <= 1'b1;
		end
	end
endmodule // remote_modem_model

// ===== test_uart_auto_flow_and_reset.sv
`timescale 1ns/1ns
module test_uart_auto_flow_and_reset;
	logic                    sys_clk, rst, strobe_mode, pause_req;
	uart_afc_pkg::host_req_s host_req;
	logic [7:0]              rd_data;
	logic [6:0]              rx_fill;
	logic                    tx_char_start, tx_char_done, tx_allow;
	logic                    cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin;
	logic                    rts_n, dtr_n, tx_line, irq, irq_oe_n;
	logic                    user_output_first_n, user_output_second_n;
	logic                    receive_ready_n, receive_ready_oe_n;
	logic                    transmit_ready_n, transmit_ready_oe_n;
	int                      err_total, total_checks, cycle_cnt;

	uart_auto_flow_and_reset u_uart_auto_flow_and_reset (
		.sys_clk(sys_clk), .rst(rst), .host_req(host_req),
		.rd_data(rd_data), .strobe_mode(strobe_mode), .rx_fill(rx_fill),
		.tx_char_start(tx_char_start), .tx_char_done(tx_char_done),
		.tx_allow(tx_allow), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
		.ri_n_pin(ri_n_pin), .cd_n_pin(cd_n_pin), .rts_n(rts_n),
		.dtr_n(dtr_n), .user_output_first_n(user_output_first_n),
		.user_output_second_n(user_output_second_n), .tx_line(tx_line),
		.receive_ready_n(receive_ready_n),
		.receive_ready_oe_n(receive_ready_oe_n),
		.transmit_ready_n(transmit_ready_n),
		.transmit_ready_oe_n(transmit_ready_oe_n),
		.irq(irq), .irq_oe_n(irq_oe_n));

	remote_modem_model u_remote_modem_model (
		.sys_clk(sys_clk), .rst(rst), .pause_req(pause_req),
		.tx_allow(tx_allow), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
		.ri_n_pin(ri_n_pin), .cd_n_pin(cd_n_pin),
		.tx_char_start(tx_char_start), .tx_char_done(tx_char_done));

	// Clock and cycle ceiling
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycle_cnt++;
		if (cycle_cnt == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One-cycle write strobe, then idle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		host_req <= {1'b0, 1'b1, a, d};
		@(posedge sys_clk);
		host_req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		host_req <= {1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk);
		host_req <= '0;
		#1;
		chk($sformatf("reg %h", a), rd_data, exp);
	endtask

	task automatic set_fill(input logic [6:0] v);
		@(posedge sys_clk);
		rx_fill <= v;
		cyc(4);
	endtask

	task automatic wait_allow(input logic v);
		int n;
		n = 0;
		while (tx_allow !== v && n < 20) begin
			cyc(1);
			n++;
		end
		chk("tx_allow", {7'h00, tx_allow}, {7'h00, v});
	endtask

	// Reset state of pins and of all sixteen registers
	task automatic t_reset(input logic mode);
		logic [7:0] tbl [16] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60,
			8'h90, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h08, 8'h00};
		@(posedge sys_clk);
		strobe_mode <= mode;
		rst         <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("pins", {rts_n, dtr_n, user_output_first_n, user_output_second_n,
			tx_line, receive_ready_n, transmit_ready_n, irq}, 8'hFC);
		chk("oe", {5'h00, receive_ready_oe_n, transmit_ready_oe_n, irq_oe_n},
			{5'h00, {3{~mode}}});
		for (int i = 0; i < 16; i++)
			rchk(i[3:0], tbl[i]);
		wr(4'h5, 8'h00);
		rchk(4'h5, 8'h60);
	endtask

	// Flow characters written with an idle cycle between writes, then read back
	task automatic t_chars();
		for (int i = 0; i < 4; i++)
			wr(4'h9 + i[3:0], 8'hC3 ^ i[7:0]);
		for (int i = 0; i < 4; i++)
			rchk(4'h9 + i[3:0], 8'hC3 ^ i[7:0]);
	endtask

	// Modem outputs follow their control bits
	task automatic t_gpio();
		for (int b = 0; b < 4; b++) begin
			wr(4'h4, 8'h01 << b);
			cyc(3);
			chk("modem out", {4'h0, user_output_second_n, user_output_first_n,
				rts_n, dtr_n}, {4'h0, ~(4'h1 << b)});
		end
		wr(4'h4, 8'h00);
	endtask

	// Automatic request-to-send with hysteresis and interrupt
	task automatic t_auto_rts();
		wr(4'h8, 8'h40);
		set_fill(7'd20);
		chk("rts unarmed", {7'h00, rts_n}, 8'h01);
		set_fill(7'd0);
		wr(4'hF, 8'h03);
		wr(4'h0, 8'h01);
		wr(4'h4, 8'h02);
		cyc(3);
		chk("rts armed", {7'h00, rts_n}, 8'h00);
		set_fill(7'd11);
		chk("rts 11", {6'h00, rts_n, irq}, 8'h01);
		rchk(4'h2, 8'h04);
		set_fill(7'd12);
		chk("rts 12", {7'h00, rts_n}, 8'h01);
		set_fill(7'd4);
		chk("rts 4", {7'h00, rts_n}, 8'h01);
		set_fill(7'd3);
		chk("rts 3", {7'h00, rts_n}, 8'h00);
		wr(4'h0, 8'h00);
		cyc(2);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wr(4'hF, 8'h01);
		rchk(4'h2, 8'h01);
		wr(4'hD, 8'h01);
		set_fill(7'd15);
		chk("rts 15", {7'h00, rts_n}, 8'h00);
		set_fill(7'd16);
		chk("rts 16", {7'h00, rts_n}, 8'h01);
		set_fill(7'd0);
		wr(4'h8, 8'h00);
		wr(4'h4, 8'h00);
	endtask

	// Clear-to-send gates the transmitter only when enabled
	task automatic t_auto_cts();
		@(posedge sys_clk);
		pause_req <= 1'b1;
		cyc(8);
		chk("cts off", {7'h00, tx_allow}, 8'h01);
		wr(4'h8, 8'h80);
		wait_allow(1'b0);
		@(posedge sys_clk);
		pause_req <= 1'b0;
		wait_allow(1'b1);
		wr(4'h8, 8'h00);
	endtask

	initial begin
		rst          = 1'b1;
		host_req     = '0;
		strobe_mode  = 1'b1;
		rx_fill      = 7'd0;
		pause_req    = 1'b0;
		err_total    = 0;
		total_checks = 0;
		cycle_cnt    = 0;
		t_reset(1'b0);
		t_reset(1'b1);
		t_chars();
		t_gpio();
		t_auto_rts();
		t_auto_cts();
		print_verdict();
	end
endmodule // test_uart_auto_flow_and_reset
